// [inc/bus_switch_pkg.sv]
// package: constants for the two-channel i2c bus switch control logic
package bus_switch_pkg;
    // ------------------------------------------------------------
    // addressing and register layout
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_FIXED     = 5'h0E;  // upper five address bits, arbitrary value
    localparam int         CTRL_CH0_BIT   = 0;
    localparam int         CTRL_CH1_BIT   = 1;
    localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
    localparam int         NUM_CH         = 2;
    localparam logic [3:0] BIT_LAST       = 4'h7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 250;
    localparam int SCL_MAX_KHZ  = 400;
    localparam int SCL_MIN_NS   = 1000000 / SCL_MAX_KHZ;        // shortest legal scl period
    localparam int SCL_MIN_CYC  = (SCL_MIN_NS * CLK_MHZ) / 1000; // clock cycles in that period
    localparam int SYNC_STAGES  = 2;
endpackage

// [inc/bus_switch_if.sv]
// interface: decoded i2c events passed from the edge detector to the slave logic
`timescale 1ns/1ps
interface bus_switch_if;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_lvl;
    modport detect (output scl_rise, output scl_fall, output start_det, output stop_det, output sda_lvl);
    modport slave  (input scl_rise, input scl_fall, input start_det, input stop_det, input sda_lvl);
endinterface

// [hdl/bus_edge_detect.sv]
// module: synchronises scl/sda and finds scl edges, start and stop
`timescale 1ns/1ps
module bus_edge_detect
    import bus_switch_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_scl,
    input  wire logic         i_sda,
    bus_switch_if.detect      ev
);
    logic [SYNC_STAGES-1:0] scl_sync_q, scl_sync_d;
    logic [SYNC_STAGES-1:0] sda_sync_q, sda_sync_d;
    logic                   scl_old_q, sda_old_q;

    // ------------------------------------------------------------
    // synchronisers, first stage feeds only the second
    // ------------------------------------------------------------
    always_comb begin
        scl_sync_d = {scl_sync_q[0], i_scl};
        sda_sync_d = {sda_sync_q[0], i_sda};
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_sync_q <= '1;
            sda_sync_q <= '1;
            scl_old_q  <= 1'b1;
            sda_old_q  <= 1'b1;
        end else begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
            scl_old_q  <= scl_sync_q[1];
            sda_old_q  <= sda_sync_q[1];
        end
    end

    // edges are relative to the previous synchronised sample, so any scl rate works whose high and low phases each last long enough for i_clk to sample them
    assign ev.scl_rise  = scl_sync_q[1] & ~scl_old_q;
    assign ev.scl_fall  = ~scl_sync_q[1] & scl_old_q;
    assign ev.start_det = scl_sync_q[1] & scl_old_q & sda_old_q & ~sda_sync_q[1];
    assign ev.stop_det  = scl_sync_q[1] & scl_old_q & ~sda_old_q & sda_sync_q[1];
    assign ev.sda_lvl   = sda_sync_q[1];
endmodule

// [hdl/bus_switch_top.sv]
// module: control logic of a two-channel i2c bus switch
`timescale 1ns/1ps
module bus_switch_top
    import bus_switch_pkg::*;
(
    input  wire logic I_CLK,
    input  wire logic I_RST_N,
    input  wire logic I_SCL,
    input  wire logic I_SDA,
    output logic      O_SDA_OE,
    input  wire logic I_ADDR_SEL_BIT0,
    input  wire logic I_ADDR_SEL_BIT1,
    input  wire logic I_DOWNSTREAM_IRQ_IN_0_N,
    input  wire logic I_DOWNSTREAM_IRQ_IN_1_N,
    output logic      O_IRQ_N,
    output logic      O_CH_EN_0,
    output logic      O_CH_EN_1
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_DATA, ST_DATA_ACK, ST_READ, ST_READ_ACK} state_e;

    bus_switch_if ev ();

    state_e       state_q, state_d;
    logic [7:0]   shift_q, shift_d;
    logic [3:0]   bit_q, bit_d;
    logic [1:0]   ctrl_q, ctrl_d;
    logic         oe_q, oe_d;
    logic         irq_q, irq_d;
    logic [1:0]   asel_q, asel_d;
    logic [1:0]   asel_m_q;
    logic [1:0]   irq_m_q, irq_s_q;

    // ------------------------------------------------------------
    // bus event detection on the upstream pair
    // ------------------------------------------------------------
    // edges are found by sampling, so a stopped scl just means no events
    bus_edge_detect u_edge (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_scl   (I_SCL),
        .i_sda   (I_SDA),
        .ev      (ev)
    );

    // ------------------------------------------------------------
    // pin synchronisers for address select and interrupt inputs
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            asel_m_q <= 2'h0;
            irq_m_q  <= 2'h3;
            irq_s_q  <= 2'h3;
        end else begin
            asel_m_q <= {I_ADDR_SEL_BIT1, I_ADDR_SEL_BIT0};
            irq_m_q  <= {I_DOWNSTREAM_IRQ_IN_1_N, I_DOWNSTREAM_IRQ_IN_0_N};
            irq_s_q  <= irq_m_q;
        end
    end

    // ------------------------------------------------------------
    // slave protocol: address, write data, read back
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bit_d   = bit_q;
        ctrl_d  = ctrl_q;
        oe_d    = oe_q;
        asel_d  = asel_m_q;
        irq_d   = &irq_s_q;
        if (ev.stop_det) begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
        end else if (ev.start_det) begin
            // repeated start restarts address phase
            state_d = ST_ADDR;
            bit_d   = 4'h0;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_DATA: begin
                    if (ev.scl_rise) begin
                        shift_d = {shift_q[6:0], ev.sda_lvl};
                        bit_d   = bit_q + 4'h1;
                    end
                    if (ev.scl_fall && bit_q == (BIT_LAST + 4'h1)) begin
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == {ADDR_FIXED, asel_q}) begin
                                oe_d    = 1'b1;
                                state_d = ST_ADDR_ACK;
                            end else begin
                                state_d = ST_IDLE;
                            end
                        end else begin
                            ctrl_d  = shift_q[1:0];
                            oe_d    = 1'b1;
                            state_d = ST_DATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (ev.scl_fall) begin
                        bit_d = 4'h0;
                        if (shift_q[0]) begin
                            // read: present control register, msb first
                            shift_d = {6'h00, ctrl_q};
                            oe_d    = ~shift_d[7];
                            state_d = ST_READ;
                        end else begin
                            oe_d    = 1'b0;
                            state_d = ST_DATA;
                        end
                    end
                end
                ST_DATA_ACK: begin
                    if (ev.scl_fall) begin
                        oe_d    = 1'b0;
                        bit_d   = 4'h0;
                        state_d = ST_DATA;
                    end
                end
                ST_READ: begin
                    if (ev.scl_fall) begin
                        if (bit_q == BIT_LAST) begin
                            oe_d    = 1'b0;
                            state_d = ST_READ_ACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            bit_d   = bit_q + 4'h1;
                            oe_d    = ~shift_d[7];
                        end
                    end
                end
                ST_READ_ACK: begin
                    // master nack ends the read; ack sends the register again
                    if (ev.scl_rise) begin
                        state_d = ev.sda_lvl ? ST_IDLE : ST_READ_ACK;
                        bit_d   = ev.sda_lvl ? bit_q : 4'h0;
                        shift_d = {6'h00, ctrl_q};
                    end
                    if (ev.scl_fall && bit_q == 4'h0) begin
                        oe_d    = ~shift_q[7];
                        state_d = ST_READ;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    // the reset pin I_RST_N clears this path asynchronously
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_q   <= 4'h0;
            ctrl_q  <= CTRL_RESET_VAL;
            oe_q    <= 1'b0;
            irq_q   <= 1'b1;
            asel_q  <= 2'h0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            bit_q   <= bit_d;
            ctrl_q  <= ctrl_d;
            oe_q    <= oe_d;
            irq_q   <= irq_d;
            asel_q  <= asel_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign O_SDA_OE  = oe_q;
    assign O_IRQ_N   = irq_q;
    assign O_CH_EN_0 = ctrl_q[CTRL_CH0_BIT];
    assign O_CH_EN_1 = ctrl_q[CTRL_CH1_BIT];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    irq_and_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_IRQ_N == &$past(irq_s_q)) else $error("irq output not and of inputs");
    irq_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (&irq_s_q)[*2] |-> O_IRQ_N) else $error("irq low with no input");
    ctrl_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        state_q != ST_DATA |=> $stable(ctrl_q) || $past(state_q) == ST_DATA)
        else $error("ctrl changed outside data phase");
    ctrl_load_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        state_q == ST_DATA && state_d == ST_DATA_ACK |=> ctrl_q == $past(shift_q[1:0]))
        else $error("ctrl not loaded from data byte");
    addr_match_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        state_q == ST_ADDR && state_d == ST_ADDR_ACK |-> shift_q[2:1] == asel_q)
        else $error("ack given to wrong address");
    ch_map_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        state_q == ST_DATA && state_d == ST_DATA_ACK |=> O_CH_EN_0 == $past(shift_q[0]) && O_CH_EN_1 == $past(shift_q[1]))
        else $error("channel map wrong");
    reset_off_a: assert property (@(posedge I_CLK)
        $rose(I_RST_N) |-> !O_CH_EN_0 && !O_CH_EN_1 && state_q == ST_IDLE)
        else $error("channels enabled after reset");
    stop_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        ev.stop_det |=> state_q == ST_IDLE && !O_SDA_OE) else $error("stop did not idle");
    cov_write_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N) state_q == ST_DATA_ACK);
    cov_read_c:  cover property (@(posedge I_CLK) disable iff (!I_RST_N) state_q == ST_READ);
    cov_both_c:  cover property (@(posedge I_CLK) disable iff (!I_RST_N) O_CH_EN_0 && O_CH_EN_1);
    cov_irq_c:   cover property (@(posedge I_CLK) disable iff (!I_RST_N) !O_IRQ_N);
endmodule

// [test/upstream_master_model.sv]
// partner model: upstream i2c master that drives scl and pulls sda low
`timescale 1ns/1ps
module upstream_master_model (
    output logic      o_scl,
    output logic      o_sda_low,
    input  wire logic i_sda_wire
);
    // ------------------------------------------------------------
    // link timing
    // ------------------------------------------------------------
    localparam realtime HALF = 62.5; // half of the 125 ns link period
    // bus idle: scl stands still high, sda released to the pull-up
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    // start: free sda and raise scl first, so the same task also makes a repeated start mid-frame
    task automatic start();
        #(HALF/2) o_sda_low = 1'b0;
        #(HALF/2) o_scl = 1'b1;
        #HALF o_sda_low = 1'b1;
        #HALF o_scl = 1'b0;
    endtask
    // stop: sda rises while scl is high, then scl stands still
    task automatic stop();
        #(HALF/2) o_sda_low = 1'b1;
        #(HALF/2) o_scl = 1'b1;
        #HALF o_sda_low = 1'b0;
        #HALF;
    endtask
    // eight bits msb first, then the ninth bit; data only moves while scl is low
    task automatic xfer(input logic [7:0] tx, input logic m_ack, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(HALF/2) o_sda_low = ~tx[i];
            #(HALF/2) o_scl = 1'b1;
            #HALF rx[i] = i_sda_wire;
            o_scl = 1'b0;
        end
        #(HALF/2) o_sda_low = m_ack;
        #(HALF/2) o_scl = 1'b1;
        #HALF ack = ~i_sda_wire; // slave ack is a low line
        o_scl = 1'b0;
    endtask
endmodule

// [test/tb_top.sv]
// testbench: drives the bus switch through an upstream master model and checks its pins
`timescale 1ns/1ps
module tb_top;
    import bus_switch_pkg::*;
    logic       clk          = 1'b0;
    logic       rst_n        = 1'b0;
    logic [1:0] addr_pins    = 2'h0;
    logic [1:0] irq_n        = 2'h3;
    logic       scl;
    logic       sda_low;
    logic       sda_oe;
    logic       irq_out_n;
    logic       ch0;
    logic       ch1;
    wire        sda_wire     = ~(sda_low | sda_oe); // pull-up: a released line reads high
    int         bad_count    = 0;
    int         total_checks = 0;
    int         cycles       = 0;
    always #2 clk = ~clk;
    upstream_master_model mst (.o_scl(scl), .o_sda_low(sda_low), .i_sda_wire(sda_wire));
    bus_switch_top DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda_wire), .O_SDA_OE(sda_oe),
        .I_ADDR_SEL_BIT0(addr_pins[0]), .I_ADDR_SEL_BIT1(addr_pins[1]), .I_DOWNSTREAM_IRQ_IN_0_N(irq_n[0]),
        .I_DOWNSTREAM_IRQ_IN_1_N(irq_n[1]), .O_IRQ_N(irq_out_n), .O_CH_EN_0(ch0), .O_CH_EN_1(ch1));
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // wait whole cycles, then step off the edge so register updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one write: address byte, then a data byte only if the address was acked
    task automatic wr(input logic [6:0] a, input logic [7:0] d, output logic ack);
        logic [7:0] rx;
        logic       k;
        mst.start();
        mst.xfer({a, 1'b0}, 1'b0, rx, ack);
        if (ack) begin
            mst.xfer(d, 1'b0, rx, k);
            check({7'h00, k}, 8'h01);
        end
        mst.stop();
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        settle(4);
        check({6'h00, ch1, ch0}, 8'h00);
        check({7'h00, irq_out_n}, 8'h01);
        check({7'h00, sda_oe}, 8'h00);
        $display("test reset values done");
    endtask
    // every address pin setting: the neighbour address is refused, the own one selects
    task automatic t_addr();
        logic       ack;
        logic [1:0] prev;
        prev = 2'h0;
        for (int a = 0; a < 4; a++) begin
            @(posedge clk) addr_pins <= a[1:0];
            settle(4);
            wr({ADDR_FIXED, a[1:0] ^ 2'h1}, 8'hFF, ack);
            check({7'h00, ack}, 8'h00);
            check({6'h00, ch1, ch0}, {6'h00, prev});
            wr({ADDR_FIXED, a[1:0]}, {6'h3F, a[1:0]}, ack);
            check({7'h00, ack}, 8'h01);
            check({6'h00, ch1, ch0}, {6'h00, a[1:0]});
            prev = a[1:0];
        end
        $display("test address and select done");
    endtask
    // read-back behind a repeated start, link clock stopped between bytes, master ack sends it again
    task automatic t_read();
        logic       ack;
        logic [7:0] rx;
        @(posedge clk) addr_pins <= 2'h0;
        settle(4);
        wr({ADDR_FIXED, 2'h0}, 8'h02, ack);
        mst.start();
        mst.xfer({ADDR_FIXED, 2'h0, 1'b0}, 1'b0, rx, ack);
        check({7'h00, ack}, 8'h01);
        mst.start();
        mst.xfer({ADDR_FIXED, 2'h0, 1'b1}, 1'b0, rx, ack);
        check({7'h00, ack}, 8'h01);
        #5000;
        mst.xfer(8'hFF, 1'b1, rx, ack);
        check(rx, 8'h02);
        mst.xfer(8'hFF, 1'b0, rx, ack);
        mst.stop();
        check(rx, 8'h02);
        check({6'h00, ch1, ch0}, 8'h02);
        $display("test read-back done");
    endtask
    task automatic t_irq();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) irq_n <= k[1:0];
            settle(5);
            check({7'h00, irq_out_n}, {7'h00, &k[1:0]});
        end
        $display("test interrupt combine done");
    endtask
    // reset in mid-transaction drops the selection; the bus then works again
    task automatic t_reset_mid();
        logic       ack;
        logic [7:0] rx;
        wr({ADDR_FIXED, 2'h0}, 8'h03, ack);
        check({6'h00, ch1, ch0}, 8'h03);
        mst.start();
        mst.xfer({ADDR_FIXED, 2'h0, 1'b0}, 1'b0, rx, ack);
        check({7'h00, ack}, 8'h01);
        @(posedge clk) rst_n <= 1'b0;
        settle(2);
        check({6'h00, ch1, ch0}, 8'h00);
        check({7'h00, sda_oe}, 8'h00);
        @(posedge clk) rst_n <= 1'b1;
        mst.stop();
        settle(4);
        wr({ADDR_FIXED, 2'h0}, 8'h01, ack);
        check({6'h00, ch1, ch0}, 8'h01);
        $display("test reset in mid-run done");
    endtask
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_addr();
        t_read();
        t_irq();
        t_reset_mid();
        end_sim();
    end
    // about 9000 cycles expected; a stuck bus should not run forever
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            end_sim();
        end
    end
endmodule
